// file: core/fslk_pkg.sv
// Constants and types shared by the flash sector lock register block
package fslk_pkg;
  // Register word indices; byte address is four times the index
  localparam logic [11:0] FSLK_IDX_CTRL = 12'hff8;
  localparam logic [11:0] FSLK_IDX_SHARED = 12'hff9;
  localparam logic [11:0] FSLK_IDX_KHZ_HI = 12'hffa;
  localparam logic [11:0] FSLK_IDX_KHZ_LO = 12'hffb;
  localparam logic [11:0] FSLK_IDX_STAT = 12'hffc;
  localparam logic [11:0] FSLK_IDX_CFG = 12'hffd;
  localparam logic [11:0] FSLK_IDX_NONE = 12'h000;
  // Index field position inside the byte address
  localparam int FSLK_IDX_LSB = 2;
  localparam int FSLK_IDX_MSB = 13;
  // Control codes
  localparam logic [7:0] FSLK_CODE_LOCK_SEL = 8'h5e;
  localparam logic [7:0] FSLK_CODE_PAGE_ERASE = 8'h95;
  // Values after reset
  localparam logic [7:0] FSLK_LOCK_RESET = 8'h00;
  localparam logic [7:0] FSLK_PAGE_RESET = 8'h00;
  localparam logic [7:0] FSLK_KHZ_HI_RESET = 8'h00;
  localparam logic [7:0] FSLK_KHZ_LO_RESET = 8'h00;
  // Memory configurations
  typedef enum logic [1:0] {
    FSLK_MEM_8K = 2'h0,
    FSLK_MEM_4K = 2'h1,
    FSLK_MEM_2K = 2'h2,
    FSLK_MEM_1K = 2'h3
  } fslk_mem_t;
  localparam logic [1:0] FSLK_CFG_RESET = 2'h0;
  // Sector sizes in bytes and lock bits in use per configuration
  localparam logic [10:0] FSLK_SECTOR_BIG = 11'h400;
  localparam logic [10:0] FSLK_SECTOR_SMALL = 11'h200;
  localparam logic [7:0] FSLK_USED_FULL = 8'hff;
  localparam logic [7:0] FSLK_USED_2K = 8'h0f;
  localparam logic [7:0] FSLK_USED_1K = 8'h03;
endpackage

// file: core/fslk_lock_if.sv
// Link between the register front end and the sector lock store
`timescale 1ns/100ps
interface fslk_lock_if;
  logic set_en;
  logic [7:0] set_bits;
  logic [7:0] lock;
  modport ctrl (output set_en, output set_bits, input lock);
  modport store (input set_en, input set_bits, output lock);
endinterface

// file: core/fslk_lock_reg.sv
// Set-only sector lock store
`timescale 1ns/100ps
module fslk_lock_reg
  import fslk_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  fslk_lock_if.store lk
);
  typedef struct packed {
    logic [7:0] lock;
  } fslk_lock_state_t;

  fslk_lock_state_t s_q;
  fslk_lock_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (lk.set_en) begin
      s_d.lock = s_q.lock | lk.set_bits;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.lock <= FSLK_LOCK_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign lk.lock = s_q.lock;

  a_lock_sticky: assert property (
    @(posedge clk) disable iff (rst)
    (lk.lock != 8'h00) |=> ((lk.lock & $past(lk.lock)) == $past(lk.lock)))
    else $error("lock bit cleared without reset");

  a_lock_reset: assert property (
    @(posedge clk) rst |=> (lk.lock == 8'h00))
    else $error("lock bits not zero after reset");

  a_lock_setbits: assert property (
    @(posedge clk) disable iff (rst)
    (lk.set_en && ce) |=> (lk.lock == ($past(lk.lock) | $past(lk.set_bits))))
    else $error("lock bits did not take written ones");
endmodule

// file: core/fslk_top.sv
// Flash sector lock, page select and clock frequency registers on AHB-Lite
`timescale 1ns/100ps
module fslk_top
  import fslk_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [7:0] SECTOR_LOCK,
  output logic [7:0] PAGE_SELECT,
  output logic [15:0] FLASH_CLK_KHZ,
  output logic [10:0] SECTOR_BYTES,
  output logic ERASE_REQ,
  output logic [7:0] ERASE_PAGE
);
  typedef struct packed {
    logic steer;
    logic [7:0] page;
    logic [7:0] khz_hi;
    logic [7:0] khz_lo;
    logic [1:0] cfg;
    logic refused;
    logic erase;
    logic [7:0] erase_page;
    logic dp;
    logic dp_wr;
    logic [11:0] dp_idx;
  } fslk_state_t;

  fslk_state_t s_q;
  fslk_state_t s_d;
  fslk_lock_if lk ();

  logic [7:0] used_mask;
  logic [7:0] lock_eff;
  logic [2:0] sector;
  logic [7:0] wbyte;
  logic mapped;
  logic wr_now;

  fslk_lock_reg u_lock (
    .clk (CLK_SYS),
    .rst (RST),
    .ce (CE),
    .lk (lk)
  );

  always_comb begin
    case (fslk_mem_t'(s_q.cfg))
      FSLK_MEM_2K: used_mask = FSLK_USED_2K;
      FSLK_MEM_1K: used_mask = FSLK_USED_1K;
      default: used_mask = FSLK_USED_FULL;
    endcase
  end
  assign lock_eff = lk.lock & used_mask;

  assign SECTOR_BYTES = (fslk_mem_t'(s_q.cfg) == FSLK_MEM_8K) ?
                        FSLK_SECTOR_BIG : FSLK_SECTOR_SMALL;
  // Pages are 512 bytes, so big sectors span two pages
  assign sector = (fslk_mem_t'(s_q.cfg) == FSLK_MEM_8K) ?
                  s_q.page[3:1] : s_q.page[2:0];

  assign wbyte = HWDATA[7:0];
  assign wr_now = s_q.dp && s_q.dp_wr;
  assign mapped = (HADDR[31:FSLK_IDX_MSB+1] == 18'h00000);

  always_comb begin
    s_d = s_q;
    s_d.erase = 1'b0;
    lk.set_en = 1'b0;
    lk.set_bits = wbyte;
    if (wr_now) begin
      case (s_q.dp_idx)
        FSLK_IDX_CTRL: begin
          s_d.steer = (wbyte == FSLK_CODE_LOCK_SEL);
          if (wbyte == FSLK_CODE_PAGE_ERASE) begin
            if (lock_eff[sector]) begin
              s_d.refused = 1'b1;
            end else begin
              s_d.erase = 1'b1;
              s_d.erase_page = s_q.page;
            end
          end
        end
        FSLK_IDX_SHARED: begin
          if (s_q.steer) begin
            lk.set_en = 1'b1;
          end else begin
            s_d.page = wbyte;
          end
          s_d.steer = 1'b0;
        end
        FSLK_IDX_KHZ_HI: s_d.khz_hi = wbyte;
        FSLK_IDX_KHZ_LO: s_d.khz_lo = wbyte;
        // Only one write per cycle, so no set can race this clear
        FSLK_IDX_STAT: begin
          if (wbyte[0]) begin
            s_d.refused = 1'b0;
          end
        end
        FSLK_IDX_CFG: s_d.cfg = wbyte[1:0];
        default: begin
        end
      endcase
    end
    // Address phase capture
    if (HSEL && HTRANS[1] && HREADY) begin
      s_d.dp = 1'b1;
      s_d.dp_wr = HWRITE;
      s_d.dp_idx = mapped ? HADDR[FSLK_IDX_MSB:FSLK_IDX_LSB] : FSLK_IDX_NONE;
    end else begin
      s_d.dp = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s_q.steer <= 1'b0;
      s_q.page <= FSLK_PAGE_RESET;
      s_q.khz_hi <= FSLK_KHZ_HI_RESET;
      s_q.khz_lo <= FSLK_KHZ_LO_RESET;
      s_q.cfg <= FSLK_CFG_RESET;
      s_q.refused <= 1'b0;
      s_q.erase <= 1'b0;
      s_q.erase_page <= FSLK_PAGE_RESET;
      s_q.dp <= 1'b0;
      s_q.dp_wr <= 1'b0;
      s_q.dp_idx <= FSLK_IDX_NONE;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // Read mux selects flops only; unmapped reads give zero
  always_comb begin
    HRDATA = 32'h00000000;
    if (s_q.dp && !s_q.dp_wr) begin
      case (s_q.dp_idx)
        FSLK_IDX_CTRL: HRDATA = {31'h00000000, s_q.steer};
        FSLK_IDX_SHARED: HRDATA = {24'h000000,
                                   s_q.steer ? lk.lock : s_q.page};
        FSLK_IDX_KHZ_HI: HRDATA = {24'h000000, s_q.khz_hi};
        FSLK_IDX_KHZ_LO: HRDATA = {24'h000000, s_q.khz_lo};
        FSLK_IDX_STAT: HRDATA = {31'h00000000, s_q.refused};
        FSLK_IDX_CFG: HRDATA = {30'h00000000, s_q.cfg};
        default: HRDATA = 32'h00000000;
      endcase
    end
  end

  // Stalling while frozen keeps writes from being lost
  assign HREADYOUT = CE;
  assign HRESP = 1'b0;
  assign SECTOR_LOCK = lk.lock;
  assign PAGE_SELECT = s_q.page;
  assign FLASH_CLK_KHZ = {s_q.khz_hi, s_q.khz_lo};
  assign ERASE_REQ = s_q.erase;
  assign ERASE_PAGE = s_q.erase_page;

  a_steer_arm: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (CE && wr_now && s_q.dp_idx == FSLK_IDX_CTRL &&
     wbyte == FSLK_CODE_LOCK_SEL) |=> s_q.steer)
    else $error("lock select code did not arm steering");

  a_lock_route: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (CE && wr_now && s_q.dp_idx == FSLK_IDX_SHARED && s_q.steer)
    |=> ((lk.lock & $past(wbyte)) == $past(wbyte)) &&
        (s_q.page == $past(s_q.page)))
    else $error("steered write did not reach lock bits");

  a_page_route: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (CE && wr_now && s_q.dp_idx == FSLK_IDX_SHARED && !s_q.steer)
    |=> (PAGE_SELECT == $past(wbyte)) && (lk.lock == $past(lk.lock)))
    else $error("plain write did not reach page select");

  a_steer_once: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (CE && wr_now && s_q.dp_idx == FSLK_IDX_SHARED) |=> !s_q.steer)
    else $error("steering stayed armed after shared write");

  a_erase_gate: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (CE && wr_now && s_q.dp_idx == FSLK_IDX_CTRL &&
     wbyte == FSLK_CODE_PAGE_ERASE)
    |=> (ERASE_REQ == !$past(lock_eff[sector])))
    else $error("page erase not gated by sector lock");

  a_khz_high: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (CE && wr_now && s_q.dp_idx == FSLK_IDX_KHZ_HI)
    |=> (FLASH_CLK_KHZ[15:8] == $past(wbyte)) &&
        (FLASH_CLK_KHZ[7:0] == $past(s_q.khz_lo)))
    else $error("high clock byte not placed in upper half");

  a_unused_bits: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (fslk_mem_t'(s_q.cfg) == FSLK_MEM_1K) |->
    (lock_eff == {6'h00, lk.lock[1:0]}))
    else $error("unused lock bits still protect");

  a_unused_2k: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (fslk_mem_t'(s_q.cfg) == FSLK_MEM_2K) |->
    (lock_eff == {4'h0, lk.lock[3:0]}))
    else $error("unused upper lock bits still protect");

  a_sector_size: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (CE && wr_now && s_q.dp_idx == FSLK_IDX_CFG)
    |=> (SECTOR_BYTES == (($past(wbyte[1:0]) == 2'h0) ?
                          11'h400 : 11'h200)))
    else $error("sector size wrong for configuration");
endmodule

// file: testbench/fslk_top_tb.sv
// Self-checking bench for the flash sector lock register block
`timescale 1ns/100ps
module fslk_top_tb
  import fslk_pkg::*;
;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic CE = 1'b1;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  logic HREADY;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, ERASE_REQ;
  logic [7:0] SECTOR_LOCK, PAGE_SELECT, ERASE_PAGE;
  logic [15:0] FLASH_CLK_KHZ;
  logic [10:0] SECTOR_BYTES;
  int failures = 0;
  int num_checks = 0;
  int erase_cnt = 0;
  logic [31:0] rdat;

  // Single slave, so its ready is the bus ready
  assign HREADY = HREADYOUT;
  always #2 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) if (ERASE_REQ === 1'b1) erase_cnt <= erase_cnt + 1;

  fslk_top u_fslk_top (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SECTOR_LOCK(SECTOR_LOCK),
    .PAGE_SELECT(PAGE_SELECT), .FLASH_CLK_KHZ(FLASH_CLK_KHZ),
    .SECTOR_BYTES(SECTOR_BYTES), .ERASE_REQ(ERASE_REQ),
    .ERASE_PAGE(ERASE_PAGE));

  task automatic end_sim;
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits on ready in both phases; only the watchdog ends a stall
  task automatic xfer(input logic w, input logic [11:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge CLK_SYS);
    HTRANS <= 2'b10;
    HWRITE <= w;
    HADDR <= {18'h0, idx, 2'h0};
    do @(posedge CLK_SYS); while (HREADY !== 1'b1);
    HTRANS <= 2'b00;
    HWDATA <= wd;
    do @(posedge CLK_SYS); while (HREADY !== 1'b1);
    rd = HRDATA;
    #1;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, idx, d, dummy);
  endtask

  task automatic try_erase(input logic [7:0] pg, input logic [31:0] n);
    int c0;
    c0 = erase_cnt;
    wr(FSLK_IDX_SHARED, {24'h0, pg});
    wr(FSLK_IDX_CTRL, {24'h0, FSLK_CODE_PAGE_ERASE});
    repeat (3) @(posedge CLK_SYS);
    #1;
    chk("erase_count", n, 32'(erase_cnt - c0));
  endtask

  task automatic t_reset;
    chk("lock", 32'h0, {24'h0, SECTOR_LOCK});
    chk("page", 32'h0, {24'h0, PAGE_SELECT});
    chk("sector_bytes", 32'h400, {21'h0, SECTOR_BYTES});
    chk("hresp", 32'h0, {31'h0, HRESP});
  endtask

  task automatic t_steer;
    wr(FSLK_IDX_SHARED, 32'h21);
    chk("page", 32'h21, {24'h0, PAGE_SELECT});
    chk("lock", 32'h0, {24'h0, SECTOR_LOCK});
    wr(FSLK_IDX_CTRL, {24'h0, FSLK_CODE_LOCK_SEL});
    wr(FSLK_IDX_SHARED, 32'h05);
    chk("lock", 32'h05, {24'h0, SECTOR_LOCK});
    chk("page", 32'h21, {24'h0, PAGE_SELECT});
    wr(FSLK_IDX_SHARED, 32'h33);
    chk("page", 32'h33, {24'h0, PAGE_SELECT});
    chk("lock", 32'h05, {24'h0, SECTOR_LOCK});
    // Any other control value withdraws the selection
    wr(FSLK_IDX_CTRL, {24'h0, FSLK_CODE_LOCK_SEL});
    wr(FSLK_IDX_CTRL, 32'h00);
    wr(FSLK_IDX_SHARED, 32'h40);
    chk("page", 32'h40, {24'h0, PAGE_SELECT});
    chk("lock", 32'h05, {24'h0, SECTOR_LOCK});
  endtask

  task automatic t_sticky;
    wr(FSLK_IDX_CTRL, {24'h0, FSLK_CODE_LOCK_SEL});
    xfer(1'b0, FSLK_IDX_SHARED, 32'h0, rdat);
    chk("rd_lock", 32'h05, rdat);
    wr(FSLK_IDX_SHARED, 32'h80);
    chk("lock", 32'h85, {24'h0, SECTOR_LOCK});
    wr(FSLK_IDX_CTRL, {24'h0, FSLK_CODE_LOCK_SEL});
    wr(FSLK_IDX_SHARED, 32'h00);
    chk("lock", 32'h85, {24'h0, SECTOR_LOCK});
    xfer(1'b0, FSLK_IDX_SHARED, 32'h0, rdat);
    chk("rd_page", 32'h40, rdat);
  endtask

  task automatic t_khz;
    wr(FSLK_IDX_KHZ_HI, 32'h4e);
    wr(FSLK_IDX_KHZ_LO, 32'h20);
    chk("khz", 32'h4e20, {16'h0, FLASH_CLK_KHZ});
    xfer(1'b0, FSLK_IDX_KHZ_HI, 32'h0, rdat);
    chk("rd_khz_hi", 32'h4e, rdat);
    wr(12'h100, 32'hff);
    xfer(1'b0, 12'h100, 32'h0, rdat);
    chk("rd_unmapped", 32'h0, rdat);
  endtask

  task automatic t_erase;
    // Lock bits 0, 2 and 7 are set; big sectors use page bits 3:1
    try_erase(8'h02, 32'h1);
    chk("erase_page", 32'h02, {24'h0, ERASE_PAGE});
    try_erase(8'h04, 32'h0);
    xfer(1'b0, FSLK_IDX_STAT, 32'h0, rdat);
    chk("refused", 32'h1, rdat);
    wr(FSLK_IDX_STAT, 32'h1);
    xfer(1'b0, FSLK_IDX_STAT, 32'h0, rdat);
    chk("refused_clr", 32'h0, rdat);
    try_erase(8'h01, 32'h0);
    for (int c = 3; c >= 0; c--) begin
      wr(FSLK_IDX_CFG, 32'(c));
      chk("sector_bytes", c == 0 ? 32'h400 : 32'h200,
          {21'h0, SECTOR_BYTES});
    end
    wr(FSLK_IDX_CFG, 32'h1);
    try_erase(8'h01, 32'h1);
    // Small parts: upper lock bits guard nothing
    wr(FSLK_IDX_CFG, 32'h2);
    try_erase(8'h07, 32'h1);
    try_erase(8'h02, 32'h0);
    wr(FSLK_IDX_CFG, 32'h3);
    try_erase(8'h02, 32'h1);
  endtask

  task automatic t_ce_rst;
    @(posedge CLK_SYS);
    CE <= 1'b0;
    fork
      wr(FSLK_IDX_SHARED, 32'h66);
      begin
        repeat (5) @(posedge CLK_SYS);
        chk("hreadyout", 32'h0, {31'h0, HREADYOUT});
        chk("page_frozen", 32'h02, {24'h0, PAGE_SELECT});
        CE <= 1'b1;
      end
    join
    chk("page", 32'h66, {24'h0, PAGE_SELECT});
    @(posedge CLK_SYS);
    RST <= 1'b1;
    @(posedge CLK_SYS);
    RST <= 1'b0;
    #1;
    chk("lock", 32'h0, {24'h0, SECTOR_LOCK});
    chk("khz", 32'h0, {16'h0, FLASH_CLK_KHZ});
  endtask

  initial begin
    repeat (10) @(posedge CLK_SYS);
    RST <= 1'b0;
    HSEL <= 1'b1;
    @(posedge CLK_SYS);
    #1;
    t_reset;
    t_steer;
    t_sticky;
    t_khz;
    t_erase;
    t_ce_rst;
    end_sim;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    failures++;
    end_sim;
  end
endmodule
